// ---- rtl/adcsq_pkg.sv ----
// Constants for the converter scan sequencer control block.
// Assumes a 32-bit APB with word-aligned registers.
package adcsq_pkg;

	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [9:0] CHSEL_IDX = 10'h0fc;
	localparam logic [9:0] SETUP_IDX = 10'h0fd;
	localparam logic [9:0] STATUS_IDX = 10'h0fe;
	localparam logic [9:0] LOW_A_IDX = 10'h0f0;
	localparam logic [9:0] LOW_B_IDX = 10'h0f1;
	localparam logic [9:0] UP_A_IDX = 10'h0f2;
	localparam logic [9:0] UP_B_IDX = 10'h0f3;
	localparam logic [9:0] RES_BASE_IDX = 10'h0e0;
	localparam logic [9:0] RES_MASK_IDX = 10'h3f0;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] CHSEL_RST = 8'h0f;
	localparam logic [7:0] SETUP_RST = 8'ha0;
	localparam logic [9:0] LOW_RST = 10'h000;
	localparam logic [9:0] UP_RST = 10'h3ff;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int FIRST_LSB = 4;
	localparam int PAIR_LSB = 0;
	localparam int DIV_LSB = 5;
	localparam int EXT_BIT = 4;
	localparam int TIM_BIT = 3;
	localparam int POW_BIT = 2;
	localparam int REP_BIT = 1;
	localparam int RUN_BIT = 0;
	localparam int DONE_BIT = 0;
	localparam int FLAG_LSB = 4;
	localparam int CUR_LSB = 8;
	localparam int BUSY_BIT = 12;

	// ----------------------------------------
	// Channels and conversion timing
	// ----------------------------------------
	localparam logic [3:0] LAST_CH = 4'hf;
	localparam logic [4:0] CONV_TICKS = 5'h1c;
	localparam logic [4:0] SAMPLE_TICKS = 5'h08;
	localparam logic [4:0] LAST_TICK = CONV_TICKS - 5'h01;

	typedef enum logic {SEQ_IDLE, SEQ_CONV} adcsq_state_t;

endpackage : adcsq_pkg

// ---- rtl/adcsq_prescaler.sv ----
// Converter clock divider: pclk divided by 2 * (code + 1).
// Assumes the code is stable while enabled; a change is compared at once, so the
// current half-period ends when the count next equals the new code.
`timescale 1ns/100ps
module adcsq_prescaler (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic enable,
	input wire logic [2:0] div_code,
	// Converter clock and its rising-edge pulse
	output logic adc_clk_q,
	output logic tick_q
);

	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	logic half_w;

	assign half_w = enable && (cnt_q == div_code);
	assign cnt_d = (!enable || half_w) ? 3'h0 : cnt_q + 3'h1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 3'h0;
			adc_clk_q <= 1'b0;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			adc_clk_q <= enable && (adc_clk_q ^ half_w);
			tick_q <= half_w && !adc_clk_q;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [4:0] gap_q;
	logic seen_q;
	logic [2:0] code_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_q <= 5'h00;
			seen_q <= 1'b0;
			code_q <= 3'h0;
		end else begin
			gap_q <= tick_q ? 5'h01 : gap_q + 5'h01;
			seen_q <= enable && (seen_q || tick_q) && (code_q == div_code);
			code_q <= div_code;
		end
	end

	a_divider_period: assert property (
		@(posedge pclk) disable iff (!presetn)
		(tick_q && seen_q && enable)
		|-> (gap_q == {1'b0, div_code, 1'b0} + 5'h02))
		else $error("converter clock period wrong for divider code");

endmodule : adcsq_prescaler

// ---- rtl/adcsq_window.sv ----
// Window compare for the two adjacent monitored channels.
// Assumes result_valid pulses for one cycle per finished conversion.
`timescale 1ns/100ps
module adcsq_window (
	// Clock and reset (checks only)
	input wire logic pclk,
	input wire logic presetn,
	// Conversion result
	input wire logic result_valid,
	input wire logic [3:0] result_ch,
	input wire logic [9:0] result,
	// Settings
	input wire logic [3:0] pair_sel,
	input wire logic [9:0] low_a,
	input wire logic [9:0] low_b,
	input wire logic [9:0] up_a,
	input wire logic [9:0] up_b,
	// Flag set pulses {b_up, a_up, b_low, a_low}
	output logic [3:0] flag_set
);

	logic [3:0] ch_a_w;
	logic hit_a_w;
	logic hit_b_w;

	assign ch_a_w = (pair_sel == 4'h0) ? adcsq_pkg::LAST_CH
		: pair_sel - 4'h1;
	assign hit_a_w = result_valid && (result_ch == ch_a_w);
	assign hit_b_w = result_valid && (result_ch == pair_sel);

	assign flag_set[3] = hit_b_w && (result > up_b);
	assign flag_set[2] = hit_a_w && (result > up_a);
	assign flag_set[1] = hit_b_w && (result < low_b);
	assign flag_set[0] = hit_a_w && (result < low_a);

	a_pair_wrap: assert property (
		@(posedge pclk) disable iff (!presetn)
		(result_valid && pair_sel == 4'h0 && result_ch == 4'hf
		&& result > up_a) |-> flag_set[2])
		else $error("channel 15 not treated as channel A for code 0");

	a_upper_only: assert property (
		@(posedge pclk) disable iff (!presetn)
		flag_set[3] |-> (result_valid && result_ch == pair_sel
		&& result > up_b))
		else $error("upper flag of channel B set without cause");

endmodule : adcsq_window

// ---- rtl/adcsq_ctrl.sv ----
// Scan sequencer control for a 16-channel 10-bit converter, APB slave.
// Assumes the converter core settles its result within one conversion
// and that trigger inputs are synchronous to pclk.
//
// Operation
// - Scan from first channel up to 15
// - First channel 15 converts only channel 15
// - Pair code selects channels N-1 and N
// - Control register write restarts from first channel
// - Converter clock is pclk over 2*(code+1)
// - Enabled pin edge starts a sequence while trigger_alt_en is high
// - Enabled timer event starts a sequence
// - Pin and timer triggers are ORed
// - Trigger sets the run bit like software
// - Single mode clears run bit at end
// - Analog enable clear powers converter down
// - Single mode: one sequence per start
// - Repeat mode restarts sequences continuously
// - Run bit one starts, zero stops
// - Done flag set when sequence ends
// - Result split into high and low bytes
// - Window flags set on threshold crossing
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
module adcsq_ctrl (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_q,
	output logic pready_q,
	output logic pslverr_q,
	// Trigger sources
	input wire logic trigger_pin,
	input wire logic trigger_alt_en,
	input wire logic timer_event,
	// Converter core and multiplexer
	input wire logic [9:0] conv_result,
	output logic adc_clk_q,
	output logic [3:0] mux_sel_q,
	output logic sample_q,
	output logic analog_power_q,
	output logic seq_busy_q
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] chsel_q;
	logic [7:1] setup_q;
	logic run_q;
	logic run_d;
	logic done_q;
	logic [3:0] flags_q;
	logic [9:0] low_a_q;
	logic [9:0] low_b_q;
	logic [9:0] up_a_q;
	logic [9:0] up_b_q;
	logic [9:0] result_mem [16];
	adcsq_pkg::adcsq_state_t state_q;
	adcsq_pkg::adcsq_state_t state_d;
	logic [3:0] ch_q;
	logic [3:0] ch_d;
	logic [4:0] cnt_q;
	logic [4:0] cnt_d;
	logic pin_prev_q;
	logic tev_prev_q;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire [9:0] idx_w = paddr[11:2];
	wire setup_ph_w = psel && !penable;
	wire wr_w = psel && penable && pwrite && pready_q;
	wire hit_chsel_w = idx_w == adcsq_pkg::CHSEL_IDX;
	wire hit_setup_w = idx_w == adcsq_pkg::SETUP_IDX;
	wire hit_status_w = idx_w == adcsq_pkg::STATUS_IDX;
	wire hit_low_a_w = idx_w == adcsq_pkg::LOW_A_IDX;
	wire hit_low_b_w = idx_w == adcsq_pkg::LOW_B_IDX;
	wire hit_up_a_w = idx_w == adcsq_pkg::UP_A_IDX;
	wire hit_up_b_w = idx_w == adcsq_pkg::UP_B_IDX;
	wire hit_res_w = (idx_w & adcsq_pkg::RES_MASK_IDX)
		== adcsq_pkg::RES_BASE_IDX;
	wire mapped_w = hit_chsel_w || hit_setup_w || hit_status_w
		|| hit_low_a_w || hit_low_b_w || hit_up_a_w || hit_up_b_w
		|| hit_res_w;
	wire wr_chsel_w = wr_w && hit_chsel_w;
	wire wr_setup_w = wr_w && hit_setup_w;
	wire ctrl_wr_w = wr_chsel_w || wr_setup_w;

	// ----------------------------------------
	// Fields
	// ----------------------------------------
	wire [3:0] first_q_w = chsel_q[adcsq_pkg::FIRST_LSB +: 4];
	wire [3:0] pair_w = chsel_q[adcsq_pkg::PAIR_LSB +: 4];
	wire [2:0] div_w = setup_q[adcsq_pkg::DIV_LSB +: 3];
	wire ext_en_w = setup_q[adcsq_pkg::EXT_BIT];
	wire tim_en_w = setup_q[adcsq_pkg::TIM_BIT];
	wire pow_w = setup_q[adcsq_pkg::POW_BIT];
	wire rep_w = setup_q[adcsq_pkg::REP_BIT];
	wire [3:0] first_d_w = wr_chsel_w
		? pwdata[adcsq_pkg::FIRST_LSB +: 4] : first_q_w;

	// ----------------------------------------
	// Triggers
	// ----------------------------------------
	// Falling edge: the pin idles high and pulses low
	wire pin_edge_w = pin_prev_q && !trigger_pin;
	wire tev_edge_w = timer_event && !tev_prev_q;
	wire pin_trig_w = ext_en_w && trigger_alt_en && pin_edge_w;
	wire tim_trig_w = tim_en_w && tev_edge_w;
	wire trig_w = pin_trig_w || tim_trig_w;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	logic tick_w;
	logic [3:0] flag_set_w;
	wire conv_w = state_q == adcsq_pkg::SEQ_CONV;
	wire conv_end_w = conv_w && tick_w
		&& (cnt_q == adcsq_pkg::LAST_TICK);
	wire seq_end_w = conv_end_w && (ch_q == adcsq_pkg::LAST_CH);
	wire stop_w = !run_q || !pow_w;

	always_comb begin
		run_d = run_q;
		if (seq_end_w && !rep_w)
			run_d = 1'b0;
		if (wr_setup_w)
			run_d = pwdata[adcsq_pkg::RUN_BIT];
		if (trig_w)
			run_d = 1'b1;
	end

	always_comb begin
		state_d = state_q;
		ch_d = ch_q;
		cnt_d = cnt_q;
		case (state_q)
			adcsq_pkg::SEQ_IDLE: begin
				if (run_q && pow_w) begin
					state_d = adcsq_pkg::SEQ_CONV;
					ch_d = first_q_w;
					cnt_d = 5'h00;
				end
			end
			adcsq_pkg::SEQ_CONV: begin
				if (stop_w) begin
					state_d = adcsq_pkg::SEQ_IDLE;
				end else if (seq_end_w) begin
					cnt_d = 5'h00;
					ch_d = first_q_w;
					if (!rep_w)
						state_d = adcsq_pkg::SEQ_IDLE;
				end else if (conv_end_w) begin
					cnt_d = 5'h00;
					ch_d = ch_q + 4'h1;
				end else if (tick_w) begin
					cnt_d = cnt_q + 5'h01;
				end
			end
			default: state_d = adcsq_pkg::SEQ_IDLE;
		endcase
		// Abandons the current scan position
		if (ctrl_wr_w) begin
			ch_d = first_d_w;
			cnt_d = 5'h00;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= adcsq_pkg::SEQ_IDLE;
			ch_q <= 4'h0;
			cnt_q <= 5'h00;
			run_q <= 1'b0;
			pin_prev_q <= 1'b1;
			tev_prev_q <= 1'b0;
		end else begin
			state_q <= state_d;
			ch_q <= ch_d;
			cnt_q <= cnt_d;
			run_q <= run_d;
			pin_prev_q <= trigger_pin;
			tev_prev_q <= timer_event;
		end
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chsel_q <= adcsq_pkg::CHSEL_RST;
			setup_q <= adcsq_pkg::SETUP_RST[7:1];
			low_a_q <= adcsq_pkg::LOW_RST;
			low_b_q <= adcsq_pkg::LOW_RST;
			up_a_q <= adcsq_pkg::UP_RST;
			up_b_q <= adcsq_pkg::UP_RST;
		end else begin
			if (wr_chsel_w)
				chsel_q <= pwdata[7:0];
			if (wr_setup_w)
				setup_q <= pwdata[7:1];
			if (wr_w && hit_low_a_w)
				low_a_q <= pwdata[9:0];
			if (wr_w && hit_low_b_w)
				low_b_q <= pwdata[9:0];
			if (wr_w && hit_up_a_w)
				up_a_q <= pwdata[9:0];
			if (wr_w && hit_up_b_w)
				up_b_q <= pwdata[9:0];
		end
	end

	// Write one clears; a set in the same cycle wins
	wire clr_w = wr_w && hit_status_w;
	wire done_d_w = seq_end_w
		|| (done_q && !(clr_w && pwdata[adcsq_pkg::DONE_BIT]));
	wire [3:0] flags_d_w = flag_set_w | (flags_q
		& ~(clr_w ? pwdata[adcsq_pkg::FLAG_LSB +: 4] : 4'h0));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_q <= 1'b0;
			flags_q <= 4'h0;
		end else begin
			done_q <= done_d_w;
			flags_q <= flags_d_w;
		end
	end

	// No reset on the result array; contents are undefined until converted
	always_ff @(posedge pclk) begin
		if (conv_end_w && !stop_w)
			result_mem[ch_q] <= conv_result;
	end

	// ----------------------------------------
	// Read path and pins
	// ----------------------------------------
	wire [9:0] res_w = result_mem[paddr[5:2]];
	wire [15:0] res_rd_w = {res_w[9:2], res_w[1:0], 6'h00};
	wire [31:0] status_rd_w = {19'h0, seq_busy_q, ch_q, flags_q,
		3'h0, done_q};
	wire [31:0] rd_w = hit_chsel_w ? {24'h0, chsel_q}
		: hit_setup_w ? {24'h0, setup_q, run_q}
		: hit_status_w ? status_rd_w
		: hit_low_a_w ? {22'h0, low_a_q}
		: hit_low_b_w ? {22'h0, low_b_q}
		: hit_up_a_w ? {22'h0, up_a_q}
		: hit_up_b_w ? {22'h0, up_b_q}
		: hit_res_w ? {16'h0, res_rd_w}
		: 32'h0;
	wire sample_d_w = (state_d == adcsq_pkg::SEQ_CONV)
		&& (cnt_d < adcsq_pkg::SAMPLE_TICKS);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			mux_sel_q <= 4'h0;
			sample_q <= 1'b0;
			analog_power_q <= 1'b0;
			seq_busy_q <= 1'b0;
		end else begin
			if (setup_ph_w)
				prdata_q <= pwrite ? 32'h0 : rd_w;
			pready_q <= setup_ph_w;
			pslverr_q <= setup_ph_w && !mapped_w;
			mux_sel_q <= ch_d;
			sample_q <= sample_d_w;
			analog_power_q <= wr_setup_w ? pwdata[adcsq_pkg::POW_BIT]
				: pow_w;
			seq_busy_q <= state_d == adcsq_pkg::SEQ_CONV;
		end
	end

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	adcsq_prescaler u_prescaler (
		.pclk(pclk),
		.presetn(presetn),
		.enable(pow_w && conv_w),
		.div_code(div_w),
		.adc_clk_q(adc_clk_q),
		.tick_q(tick_w)
	);

	adcsq_window u_window (
		.pclk(pclk),
		.presetn(presetn),
		.result_valid(conv_end_w && !stop_w),
		.result_ch(ch_q),
		.result(conv_result),
		.pair_sel(pair_w),
		.low_a(low_a_q),
		.low_b(low_b_q),
		.up_a(up_a_q),
		.up_b(up_b_q),
		.flag_set(flag_set_w)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_seq_end_single;
		seq_end_w && !rep_w && !trig_w && !wr_setup_w;
	endsequence

	sequence s_seq_end_repeat;
		seq_end_w && rep_w && !stop_w && !ctrl_wr_w;
	endsequence

	a_first_channel: assert property (
		@(posedge pclk) disable iff (!presetn)
		(!conv_w && run_q && pow_w && !ctrl_wr_w)
		|=> (conv_w && ch_q == $past(first_q_w) && cnt_q == 5'h00))
		else $error("sequence did not start at first channel");

	a_chan_step: assert property (
		@(posedge pclk) disable iff (!presetn)
		(conv_end_w && !seq_end_w && !stop_w && !ctrl_wr_w)
		|=> (ch_q == $past(ch_q) + 4'h1))
		else $error("channel did not advance by one");

	a_only_fifteen: assert property (
		@(posedge pclk) disable iff (!presetn)
		(conv_w && first_q_w == adcsq_pkg::LAST_CH && $stable(first_q_w)
		&& $past(conv_w)) |-> (ch_q == adcsq_pkg::LAST_CH))
		else $error("channel other than 15 converted");

	a_write_restart: assert property (
		@(posedge pclk) disable iff (!presetn)
		ctrl_wr_w |=> (cnt_q == 5'h00 && ch_q == first_q_w))
		else $error("control write did not restart the scan");

	a_trig_sets_run: assert property (
		@(posedge pclk) disable iff (!presetn)
		trig_w |=> run_q)
		else $error("accepted trigger did not set run bit");

	a_trig_ignored: assert property (
		@(posedge pclk) disable iff (!presetn)
		(!ext_en_w && !tim_en_w && !run_q && !wr_setup_w) |=> !run_q)
		else $error("run bit set with both triggers disabled");

	a_single_clear: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_seq_end_single |=> (!run_q && !conv_w) ##1 !conv_w)
		else $error("single mode did not stop after sequence");

	a_repeat_again: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_seq_end_repeat |=> (conv_w && run_q && ch_q == $past(first_q_w)))
		else $error("repeat mode did not restart sequence");

	a_done_flag: assert property (
		@(posedge pclk) disable iff (!presetn)
		seq_end_w |=> done_q)
		else $error("done flag not set at sequence end");

	a_power_down: assert property (
		@(posedge pclk) disable iff (!presetn)
		(!pow_w && !wr_setup_w) |=> (!conv_w && !sample_q) ##1 !adc_clk_q)
		else $error("converter active while powered down");

endmodule : adcsq_ctrl

// ---- sim/adcsq_core_model.sv ----
// Converter core, multiplexer and trigger sources facing the scan control.
// Assumes pclk is the only clock; triggers change just after its edge.
`timescale 1ns/100ps
module adcsq_core_model (
	// Clock
	input wire logic pclk,
	// From the control block
	input wire logic [3:0] mux_sel_q,
	input wire logic seq_busy_q,
	// To the control block
	output logic [9:0] conv_result,
	output logic trigger_pin,
	output logic timer_event
);
	logic [9:0] junk_q = 10'h2aa;

	// Idle result toggles so a stale capture cannot pass
	always @(posedge pclk) junk_q <= ~junk_q;
	assign conv_result = seq_busy_q ? {mux_sel_q, 6'h15} : junk_q;

	initial begin
		trigger_pin = 1'b1;
		timer_event = 1'b0;
	end

	task pulse_pin;
		@(posedge pclk) trigger_pin <= 1'b0;
		repeat (2) @(posedge pclk);
		trigger_pin <= 1'b1;
	endtask : pulse_pin

	task pulse_timer;
		@(posedge pclk) timer_event <= 1'b1;
		@(posedge pclk) timer_event <= 1'b0;
	endtask : pulse_timer
endmodule : adcsq_core_model

// ---- sim/adcsq_ctrl_tb.sv ----
// Self-checking bench for the scan sequencer control over APB.
// Assumes the core model answers every channel with its number.
`timescale 1ns/100ps
module adcsq_ctrl_tb;
	localparam logic [11:0] A_CH = 12'h3f0;
	localparam logic [11:0] A_SET = 12'h3f4;
	localparam logic [11:0] A_ST = 12'h3f8;
	logic pclk, presetn, psel, penable, pwrite, trigger_pin, trigger_alt_en;
	logic timer_event, pready_q, pslverr_q, adc_clk_q, sample_q;
	logic analog_power_q, seq_busy_q, samp_d, er, new_ch;
	logic [3:0] mux_d;
	int gap, lg, sw, hw;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata_q, rd;
	logic [9:0] conv_result;
	logic [3:0] mux_sel_q;
	logic [3:0] seen[$];
	int err_count, checked, n;

	adcsq_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
		.trigger_pin(trigger_pin), .trigger_alt_en(trigger_alt_en),
		.timer_event(timer_event), .conv_result(conv_result),
		.adc_clk_q(adc_clk_q), .mux_sel_q(mux_sel_q), .sample_q(sample_q),
		.analog_power_q(analog_power_q), .seq_busy_q(seq_busy_q));
	adcsq_core_model core (.pclk(pclk), .mux_sel_q(mux_sel_q),
		.seq_busy_q(seq_busy_q), .conv_result(conv_result),
		.trigger_pin(trigger_pin), .timer_event(timer_event));

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// Channel of every conversion, at the start of its sampling
	// A restart inside the sampling phase keeps sample_q high
	assign new_ch = sample_q === 1'b1
		&& (samp_d === 1'b0 || mux_sel_q !== mux_d);
	initial samp_d = 1'b0;
	always @(posedge pclk) begin
		samp_d <= sample_q;
		mux_d <= mux_sel_q;
		hw <= (sample_q === 1'b1) ? hw + 1 : 0;
		if (sample_q === 1'b0 && samp_d === 1'b1) sw <= hw;
		lg <= new_ch ? gap : lg;
		gap <= new_ch ? 1 : gap + 1;
		if (new_ch) seen.push_back(mux_sel_q);
	end

	// ---
	// Tasks
	// ---
	task close_out;
		$display("mismatches %0d, comparisons %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready_q !== 1'b1 && k < 20);
		rd = prdata_q;
		er = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			err_count++;
			close_out();
		end
	endtask : apb

	task rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd & 32'hff, exp);
	endtask : rdchk

	// Bounded wait on busy, or on a count of conversions seen
	task wait_for(input logic v, input int cnt);
		int i;
		for (i = 0; i < 9000; i++) begin
			if (cnt == 0 && seq_busy_q === v) return;
			if (cnt > 0 && seen.size() >= cnt) return;
			@(posedge pclk);
		end
		err_count++;
		close_out();
	endtask : wait_for

	task chk_seen(input logic [3:0] e[$]);
		chk(32'(seen.size()), 32'(e.size()));
		foreach (e[i]) chk({28'h0, seen[i]}, {28'h0, e[i]});
		seen = {};
	endtask : chk_seen

	// Pclk edges between two rising converter clock edges
	task clk_period;
		int k, r;
		logic p;
		p = 1'b1;
		r = 0;
		n = 0;
		for (k = 0; k < 200 && r < 2; k++) begin
			@(posedge pclk);
			if (r == 1) n++;
			if (adc_clk_q === 1'b1 && p === 1'b0) r++;
			p = adc_clk_q;
		end
	endtask : clk_period

	task idle_chk;
		repeat (20) @(posedge pclk);
		chk({31'h0, seq_busy_q}, 32'h0);
	endtask : idle_chk

	// ---
	// Main sequence
	// ---
	initial begin
		err_count = 0;
		checked = 0;
		presetn = 1'b0;
		{psel, penable, pwrite, trigger_alt_en} = 4'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(A_CH, 32'h0f);
		rdchk(A_SET, 32'ha0);
		apb(1'b0, 12'h004, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, 12'h3c8, 32'h300);
		apb(1'b1, 12'h3c4, 32'h3a0);
		apb(1'b0, 12'h3c8, 32'h0);
		chk(rd, 32'h300);
		apb(1'b1, A_CH, 32'hde);
		apb(1'b1, A_SET, 32'ha5);
		wait_for(1'b1, 2);
		apb(1'b1, A_CH, 32'hde);
		wait_for(1'b1, 5);
		wait_for(1'b0, 0);
		chk_seen('{4'hd, 4'he, 4'hd, 4'he, 4'hf});
		rdchk(A_SET, 32'ha4);
		rdchk(A_ST, 32'h61);
		apb(1'b0, 12'h3b8, 32'h0);
		chk(rd, 32'he540);
		apb(1'b1, A_CH, 32'hf0);
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, A_ST, 32'hf1);
			apb(1'b1, A_SET, {24'h0, 3'(c), 5'h05});
			clk_period();
			chk(32'(n), 32'(2 * (c + 1)));
			wait_for(1'b0, 0);
			chk_seen('{4'hf});
			rdchk(A_ST, 32'h41);
		end
		// One trigger source enabled at a time, spaced past a sequence
		trigger_alt_en <= 1'b1;
		apb(1'b1, A_SET, 32'hb4);
		core.pulse_pin();
		wait_for(1'b1, 0);
		rdchk(A_SET, 32'hb5);
		wait_for(1'b0, 0);
		rdchk(A_SET, 32'hb4);
		apb(1'b1, A_SET, 32'hac);
		core.pulse_timer();
		wait_for(1'b1, 0);
		wait_for(1'b0, 0);
		chk_seen('{4'hf, 4'hf});
		apb(1'b1, A_SET, 32'ha4);
		core.pulse_pin();
		core.pulse_timer();
		idle_chk();
		apb(1'b1, A_SET, 32'hb4);
		trigger_alt_en <= 1'b0;
		core.pulse_pin();
		idle_chk();
		apb(1'b1, A_SET, 32'ha7);
		wait_for(1'b1, 3);
		rdchk(A_SET, 32'ha7);
		chk(32'(lg), 32'(28 * 2 * (5 + 1)));
		chk(32'(sw), 32'(8 * 2 * (5 + 1)));
		apb(1'b1, A_SET, 32'ha4);
		repeat (2) @(posedge pclk);
		chk({31'h0, seq_busy_q}, 32'h0);
		chk({31'h0, analog_power_q}, 32'h1);
		apb(1'b1, A_SET, 32'ha1);
		idle_chk();
		chk({30'h0, analog_power_q, adc_clk_q}, 32'h0);
		close_out();
	end
endmodule : adcsq_ctrl_tb
